//--- hdl/gpcm_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the
  six-pin configuration and routing block.
  Assumes it is included by bare name from the block's source files.
*/
`ifndef GPCM_DEFINES_SVH
`define GPCM_DEFINES_SVH

// Pin and channel counts
`define GPCM_NUM_PINS       6
`define GPCM_NUM_CHANNELS   4

// Register port geometry
`define GPCM_ADDR_W         8
`define GPCM_DATA_W         16

// Register addresses, one per pin, consecutive
`define GPCM_ADDR_FIRST     8'h32
`define GPCM_ADDR_LAST      8'h37
`define GPCM_CFG_RESET      16'h0008

// Field positions inside a pin register
`define GPCM_MODE_LSB       0
`define GPCM_MODE_MSB       2
`define GPCM_PD_BIT         3
`define GPCM_OUT_BIT        4
`define GPCM_IN_BIT         5
`define GPCM_CH_LSB         6
`define GPCM_CH_MSB         7

// Input conditioning, in system clock periods
`define GPCM_GLITCH_CYCLES  4
`define GPCM_PIPE_STAGES    2

`endif

//--- hdl/gpcm_pkg.sv
/*
  Types shared by the pin configuration block.
  Assumes gpcm_defines.svh is compiled alongside for the numbers.
*/
package gpcm_pkg;

  // Pin mode codes; every other code behaves as high impedance
  typedef enum logic [2:0]
  {
    GPCM_MODE_HIZ     = 3'h0,
    GPCM_MODE_GPIO    = 3'h1,
    GPCM_MODE_INPUT   = 3'h2,
    GPCM_MODE_DIN_OUT = 3'h3,
    GPCM_MODE_FET_SRC = 3'h4
  } gpcm_mode_t;

  typedef logic [1:0] gpcm_chan_t;

endpackage

//--- hdl/gpcm_deglitch.sv
/*
  Two-flop synchroniser, glitch filter and latency pipeline for one pin.
  Assumes pin_raw is asynchronous to clk; all outputs are on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gpcm_deglitch
  import gpcm_pkg::*;
#(
  parameter int GLITCH_CYCLES = 4,
  parameter int PIPE_STAGES   = 2
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin side
  input  wire logic pin_raw,
  // Conditioned levels
  output logic      level_sync,
  output logic      level_filtered
);

  localparam int CW = $clog2(GLITCH_CYCLES + 1);

  generate
    if (GLITCH_CYCLES < 2 || PIPE_STAGES < 2)
    begin : g_check
      $error("gpcm_deglitch: GLITCH_CYCLES and PIPE_STAGES must be at least 2");
    end
  endgenerate

  logic                   sync1_q;
  logic                   sync2_q;
  logic                   filt_q;
  logic [CW-1:0]          cnt_q;
  logic [PIPE_STAGES-1:0] pipe_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // A new level must hold GLITCH_CYCLES samples before it is accepted
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      filt_q <= 1'b0;
      cnt_q  <= '0;
    end
    else if (sync2_q == filt_q)
      cnt_q <= '0;
    else if (cnt_q == CW'(GLITCH_CYCLES - 1))
    begin
      filt_q <= sync2_q;
      cnt_q  <= '0;
    end
    else
      cnt_q <= cnt_q + CW'(1);
  end

  // Pads latency into the documented window
  always_ff @(posedge clk)
  begin
    if (reset)
      pipe_q <= '0;
    else
      pipe_q <= {pipe_q[PIPE_STAGES-2:0], filt_q};
  end

  assign level_sync     = sync2_q;
  assign level_filtered = pipe_q[PIPE_STAGES-1];

endmodule

`default_nettype wire

//--- hdl/gpcm_fet_arbiter.sv
/*
  Picks, per channel, the pin that sources the external FET and
  selects between pin control and software data.
  Assumes all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gpcm_fet_arbiter
  import gpcm_pkg::*;
#(
  parameter int NUM_PINS     = 6,
  parameter int NUM_CHANNELS = 4
)
(
  // Clock and reset
  input  wire logic                                      clk,
  input  wire logic                                      reset,
  // Per-pin requests
  input  wire logic [NUM_PINS-1:0]                       pin_is_fet_src,
  input  wire logic [NUM_PINS*$clog2(NUM_CHANNELS)-1:0]  pin_channel,
  input  wire logic [NUM_PINS-1:0]                       pin_level,
  // Per-channel control
  input  wire logic [NUM_CHANNELS-1:0]                   fet_drive_source_select,
  input  wire logic [NUM_CHANNELS-1:0]                   fet_software_data,
  output logic      [NUM_CHANNELS-1:0]                   fet_drive,
  output logic      [NUM_CHANNELS-1:0]                   fet_pin_claimed
);

  localparam int CH_W = $clog2(NUM_CHANNELS);

  generate
    if (NUM_CHANNELS < 2 || NUM_CHANNELS != (1 << CH_W) || NUM_PINS < 1)
    begin : g_check
      $error("gpcm_fet_arbiter: NUM_CHANNELS must be a power of two, NUM_PINS positive");
    end
  endgenerate

  logic [NUM_CHANNELS-1:0] drive_q;
  logic [NUM_CHANNELS-1:0] claim_q;

  genvar c;
  generate
    for (c = 0; c < NUM_CHANNELS; c++)
    begin : g_chan
      logic claimed;
      logic level;
      // Ascending scan so the highest pin index wins
      always_comb
      begin
        claimed = 1'b0;
        level   = 1'b0;
        for (int i = 0; i < NUM_PINS; i++)
        begin
          if (pin_is_fet_src[i] && pin_channel[i*CH_W +: CH_W] == CH_W'(c))
          begin
            claimed = 1'b1;
            level   = pin_level[i];
          end
        end
      end

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          drive_q[c] <= 1'b0;
          claim_q[c] <= 1'b0;
        end
        else
        begin
          drive_q[c] <= fet_drive_source_select[c] ? level : fet_software_data[c];
          claim_q[c] <= claimed;
        end
      end
    end
  endgenerate

  assign fet_drive       = drive_q;
  assign fet_pin_claimed = claim_q;

endmodule

`default_nettype wire

//--- hdl/gpcm_top.sv
/*
  Six general-purpose pins, each with its own configuration register:
  high impedance, software output with readback, input, channel
  comparator out, or drive source for a channel's external FET.
  Assumes a simple synchronous register port on clk, pins wired to
  tri-state pads outside, and channel signals synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "gpcm_defines.svh"

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Bits 7:6 pick channel 0..3 for comparator-out and FET-source modes.
// - Bit 5 reads the pin level as seen by the input buffer.
// - Pin pulses shorter than four clocks never reach bit 5.
// - A pin change shows in bit 5 eight to nine clocks later.
// - In software output mode the pin follows output bit 4.
// - Bit 3 switches the weak pull-down on; it resets to one.
// - Mode 000 turns driver and input buffer off.
// - Mode 001 drives from bit 4 with input buffer kept on.
// - Mode 010 is input only, driver off, buffer on.
// - Mode 011 drives the selected channel's debounced comparator onto the pin.
// - Mode 100 routes the pin level to the selected channel's FET source.
// - Several pins on one channel: the highest pin index wins.
// - Undefined mode codes behave as 000, input buffer off.
// - Six registers at consecutive addresses, each resetting with pull-down only.
// - FET source selection one means pin drive, zero means software data.
module gpcm_top
  import gpcm_pkg::*;
#(
  parameter int NUM_PINS      = `GPCM_NUM_PINS,
  parameter int NUM_CHANNELS  = `GPCM_NUM_CHANNELS,
  parameter int GLITCH_CYCLES = `GPCM_GLITCH_CYCLES,
  parameter int PIPE_STAGES   = `GPCM_PIPE_STAGES
)
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Register port
  input  wire logic                       reg_wr_en,
  input  wire logic                       reg_rd_en,
  input  wire logic [`GPCM_ADDR_W-1:0]    reg_addr,
  input  wire logic [`GPCM_DATA_W-1:0]    reg_wdata,
  output logic      [`GPCM_DATA_W-1:0]    reg_rdata,
  output logic                            reg_rvalid,
  // Pads
  input  wire logic [NUM_PINS-1:0]        pin_in,
  output logic      [NUM_PINS-1:0]        pin_out,
  output logic      [NUM_PINS-1:0]        pin_oe,
  output logic      [NUM_PINS-1:0]        pin_input_buffer_enable,
  output logic      [NUM_PINS-1:0]        weak_pulldown_enable,
  output logic      [NUM_PINS-1:0]        pin_input_level,
  // Channel side
  input  wire logic [NUM_CHANNELS-1:0]    din_debounced,
  input  wire logic [NUM_CHANNELS-1:0]    fet_drive_source_select,
  input  wire logic [NUM_CHANNELS-1:0]    fet_software_data,
  output logic      [NUM_CHANNELS-1:0]    fet_drive,
  output logic      [NUM_CHANNELS-1:0]    fet_pin_claimed
);

  localparam int CH_W = $clog2(NUM_CHANNELS);

  generate
    if (NUM_PINS < 1 || NUM_PINS > (`GPCM_ADDR_LAST - `GPCM_ADDR_FIRST + 1))
    begin : g_check_pins
      $error("gpcm_top: NUM_PINS must fit the register address range");
    end
    if (NUM_CHANNELS != (1 << (`GPCM_CH_MSB - `GPCM_CH_LSB + 1)))
    begin : g_check_chan
      $error("gpcm_top: NUM_CHANNELS must match the channel-select field width");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Mode decoding, shared by the pad and readback logic; FET source compares mode_q directly

  // Only software output and comparator-out modes drive the pad
  function automatic logic mode_drives(input logic [2:0] mode);
    mode_drives = (mode == GPCM_MODE_GPIO) || (mode == GPCM_MODE_DIN_OUT);
  endfunction

  // High impedance and every undefined code switch the input buffer off
  function automatic logic mode_input_on(input logic [2:0] mode);
    mode_input_on = (mode == GPCM_MODE_GPIO) || (mode == GPCM_MODE_INPUT) ||
                    (mode == GPCM_MODE_DIN_OUT) || (mode == GPCM_MODE_FET_SRC);
  endfunction

  function automatic logic addr_hits(input logic [`GPCM_ADDR_W-1:0] addr, input int idx);
    addr_hits = (addr == `GPCM_ADDR_FIRST + `GPCM_ADDR_W'(idx));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [2:0]            mode_q   [NUM_PINS];
  logic [CH_W-1:0]       chan_q   [NUM_PINS];
  logic [NUM_PINS-1:0]   out_q;
  logic [NUM_PINS-1:0]   pd_q;

  wire  [2:0]            cfg_reset_mode = 3'(`GPCM_CFG_RESET >> `GPCM_MODE_LSB);
  wire  [CH_W-1:0]       cfg_reset_chan = CH_W'(`GPCM_CFG_RESET >> `GPCM_CH_LSB);
  wire                   cfg_reset_out  = 1'(`GPCM_CFG_RESET >> `GPCM_OUT_BIT);
  wire                   cfg_reset_pd   = 1'(`GPCM_CFG_RESET >> `GPCM_PD_BIT);

  wire  [2:0]            wr_mode = reg_wdata[`GPCM_MODE_MSB:`GPCM_MODE_LSB];
  wire  [CH_W-1:0]       wr_chan = reg_wdata[`GPCM_CH_MSB:`GPCM_CH_LSB];
  wire                   wr_out  = reg_wdata[`GPCM_OUT_BIT];
  wire                   wr_pd   = reg_wdata[`GPCM_PD_BIT];

  logic [NUM_PINS-1:0]   rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin datapath

  logic [NUM_PINS-1:0]        level_sync;
  logic [NUM_PINS-1:0]        level_filtered;
  logic [NUM_PINS-1:0]        is_fet_src;
  logic [NUM_PINS*CH_W-1:0]   pin_channel_flat;
  logic [NUM_PINS-1:0]        pin_out_q;
  logic [NUM_PINS-1:0]        pin_oe_q;
  logic [NUM_PINS-1:0]        ie_q;
  logic [NUM_PINS-1:0]        in_level_q;
  logic [`GPCM_DATA_W-1:0]    cfg_view [NUM_PINS];

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++)
    begin : g_pin
      wire   hit_wr     = reg_wr_en && addr_hits(reg_addr, p);
      wire   drives     = mode_drives(mode_q[p]);
      wire   input_on   = mode_input_on(mode_q[p]);
      wire   din_level  = din_debounced[chan_q[p]];
      wire   next_level = (mode_q[p] == GPCM_MODE_DIN_OUT) ? din_level : out_q[p];

      assign rd_hit[p] = addr_hits(reg_addr, p);

      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          mode_q[p] <= cfg_reset_mode;
          chan_q[p] <= cfg_reset_chan;
          out_q[p]  <= cfg_reset_out;
          pd_q[p]   <= cfg_reset_pd;
        end
        else if (hit_wr)
        begin
          mode_q[p] <= wr_mode;
          chan_q[p] <= wr_chan;
          out_q[p]  <= wr_out;
          pd_q[p]   <= wr_pd;
        end
      end

      // Pad drive; anything outside the two driving modes leaves it floating
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          pin_out_q[p] <= 1'b0;
          pin_oe_q[p]  <= 1'b0;
          ie_q[p]      <= 1'b0;
        end
        else
        begin
          pin_out_q[p] <= drives ? next_level : 1'b0;
          pin_oe_q[p]  <= drives;
          ie_q[p]      <= input_on;
        end
      end

      gpcm_deglitch
      #(
        .GLITCH_CYCLES (GLITCH_CYCLES),
        .PIPE_STAGES   (PIPE_STAGES)
      )
      u_deglitch
      (
        .clk            (clk),
        .reset          (reset),
        .pin_raw        (pin_in[p]),
        .level_sync     (level_sync[p]),
        .level_filtered (level_filtered[p])
      );

      // Closing register adds the last cycle of the latency window.
      // Gated by the next buffer enable so bit 5 drops with the pad buffer, not a cycle later
      always_ff @(posedge clk)
      begin
        if (reset)
          in_level_q[p] <= 1'b0;
        else
          in_level_q[p] <= level_filtered[p] & input_on;
      end

      // FET source uses the synchronised level, not the deglitched one
      assign is_fet_src[p] = (mode_q[p] == GPCM_MODE_FET_SRC);
      assign pin_channel_flat[p*CH_W +: CH_W] = chan_q[p];

      always_comb
      begin
        cfg_view[p]                                  = '0;
        cfg_view[p][`GPCM_MODE_MSB:`GPCM_MODE_LSB]   = mode_q[p];
        cfg_view[p][`GPCM_PD_BIT]                    = pd_q[p];
        cfg_view[p][`GPCM_OUT_BIT]                   = out_q[p];
        cfg_view[p][`GPCM_IN_BIT]                    = in_level_q[p];
        cfg_view[p][`GPCM_CH_MSB:`GPCM_CH_LSB]       = chan_q[p];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Register readback; unmapped addresses read as zero

  logic [`GPCM_DATA_W-1:0] rd_mux;
  logic [`GPCM_DATA_W-1:0] rdata_q;
  logic                    rvalid_q;

  always_comb
  begin
    rd_mux = '0;
    for (int i = 0; i < NUM_PINS; i++)
    begin
      if (rd_hit[i])
        rd_mux = cfg_view[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_rd_en;
      if (reg_rd_en)
        rdata_q <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External FET source selection

  gpcm_fet_arbiter
  #(
    .NUM_PINS     (NUM_PINS),
    .NUM_CHANNELS (NUM_CHANNELS)
  )
  u_fet_arbiter
  (
    .clk                     (clk),
    .reset                   (reset),
    .pin_is_fet_src          (is_fet_src),
    .pin_channel             (pin_channel_flat),
    .pin_level               (level_sync),
    .fet_drive_source_select (fet_drive_source_select),
    .fet_software_data       (fet_software_data),
    .fet_drive               (fet_drive),
    .fet_pin_claimed         (fet_pin_claimed)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata               = rdata_q;
  assign reg_rvalid              = rvalid_q;
  assign pin_out                 = pin_out_q;
  assign pin_oe                  = pin_oe_q;
  assign pin_input_buffer_enable = ie_q;
  assign weak_pulldown_enable    = pd_q;
  assign pin_input_level         = in_level_q;

endmodule

`default_nettype wire

//--- tb/gpcm_host_model.sv
/*
  Far-side logic on the six pads: resolves each wire from the block's
  driver, the host's own driver and the weak pull-down.
  Assumes the bench changes host_drive_en and host_level just after clk rises.
*/
`timescale 1ns/1ps
`default_nettype none

module gpcm_host_model
#(
  parameter int NUM_PINS = 6
)
(
  // Clock
  input  wire logic                clk,
  // Block side of the pads
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe,
  input  wire logic [NUM_PINS-1:0] weak_pulldown_enable,
  // Host driver
  input  wire logic [NUM_PINS-1:0] host_drive_en,
  input  wire logic [NUM_PINS-1:0] host_level,
  // Resolved wire
  output logic      [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] float_q = '0;

  // An undriven pad without pull-down wanders, so never let it look settled
  always @(posedge clk)
    float_q <= ~float_q;

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_drive_en & host_level)
                | (~pin_oe & ~host_drive_en & ~weak_pulldown_enable & float_q);
endmodule

`default_nettype wire

//--- tb/gpcm_top_chk.sv
/*
  Concurrent checks on the pin configuration block, bound into gpcm_top.
  Assumes the bench exercises pin 0 in every mode it checks here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpcm_defines.svh"

module gpcm_top_chk
#(
  parameter int NUM_PINS     = 6,
  parameter int NUM_CHANNELS = 4
)
(
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     reset,
  // Register port
  input wire logic                     reg_wr_en,
  input wire logic                     reg_rd_en,
  input wire logic [`GPCM_ADDR_W-1:0]  reg_addr,
  input wire logic [`GPCM_DATA_W-1:0]  reg_wdata,
  input wire logic [`GPCM_DATA_W-1:0]  reg_rdata,
  input wire logic                     reg_rvalid,
  // Pads
  input wire logic [NUM_PINS-1:0]      pin_in,
  input wire logic [NUM_PINS-1:0]      pin_out,
  input wire logic [NUM_PINS-1:0]      pin_oe,
  input wire logic [NUM_PINS-1:0]      pin_input_buffer_enable,
  input wire logic [NUM_PINS-1:0]      weak_pulldown_enable,
  input wire logic [NUM_PINS-1:0]      pin_input_level,
  // Channel side
  input wire logic [NUM_CHANNELS-1:0]  din_debounced,
  input wire logic [NUM_CHANNELS-1:0]  fet_drive_source_select,
  input wire logic [NUM_CHANNELS-1:0]  fet_software_data,
  input wire logic [NUM_CHANNELS-1:0]  fet_drive,
  input wire logic [NUM_CHANNELS-1:0]  fet_pin_claimed
);
  logic [2:0] mode0_q;
  logic [1:0] ch0_q;
  wire        cfg0_wr = reg_wr_en && reg_addr == 8'h32;
  wire        din_sel = din_debounced[ch0_q];

  always_ff @(posedge clk)
    if (reset)
    begin
      mode0_q <= 3'h0;
      ch0_q   <= 2'h0;
    end
    else if (cfg0_wr)
    begin
      mode0_q <= reg_wdata[2:0];
      ch0_q   <= reg_wdata[7:6];
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  gpio_drive_a: assert property (cfg0_wr && reg_wdata[2:0] == 3'h1 |-> ##2
    pin_oe[0] && pin_input_buffer_enable[0] && pin_out[0] == $past(reg_wdata[4], 2)) else $error("gpio drive");
  hiz_off_a: assert property (cfg0_wr && (reg_wdata[2:0] == 3'h0 || reg_wdata[2:0] > 3'h4) |-> ##2
    !pin_oe[0] && !pin_input_buffer_enable[0]) else $error("hiz mode");
  input_only_a: assert property (cfg0_wr && reg_wdata[2:0] == 3'h2 |-> ##2
    !pin_oe[0] && pin_input_buffer_enable[0]) else $error("input mode");
  pulldown_follow_a: assert property (cfg0_wr |=> weak_pulldown_enable[0] == $past(reg_wdata[3]))
    else $error("pulldown");
  buf_off_zero_a: assert property ((pin_input_level & ~pin_input_buffer_enable) == '0)
    else $error("level with buffer off");
  level_late_a: assert property ($rose(pin_in[0]) && pin_input_buffer_enable[0] ##1
    (pin_in[0] && pin_input_buffer_enable[0])[*8] ##1 pin_in[0] |-> pin_input_level[0]) else $error("level late");
  glitch_block_a: assert property ((!pin_in[0])[*8] ##1 pin_in[0][*3] ##1 !pin_in[0]
    |-> (!pin_input_level[0])[*8]) else $error("glitch passed");
  din_out_a: assert property (mode0_q == 3'h3 && $past(mode0_q) == 3'h3 |->
    pin_oe[0] && pin_out[0] == $past(din_sel)) else $error("comparator out");
  fet_sw_a: assert property (!$past(reset) |-> ((fet_drive ^ $past(fet_software_data))
    & ~$past(fet_drive_source_select)) == '0) else $error("fet software");
  read_bit5_a: assert property (reg_rvalid && $past(reg_addr) == 8'h32 |->
    reg_rdata[5] == $past(pin_input_level[0])) else $error("read level");

  cover property (cfg0_wr && reg_wdata[2:0] == 3'h3);
  cover property ($rose(pin_input_level[0]));
  cover property (|(fet_drive & fet_drive_source_select));
endmodule

bind gpcm_top gpcm_top_chk #(.NUM_PINS(NUM_PINS), .NUM_CHANNELS(NUM_CHANNELS)) chk_u (
  .clk(clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_input_buffer_enable(pin_input_buffer_enable),
  .weak_pulldown_enable(weak_pulldown_enable), .pin_input_level(pin_input_level),
  .din_debounced(din_debounced), .fet_drive_source_select(fet_drive_source_select),
  .fet_software_data(fet_software_data), .fet_drive(fet_drive), .fet_pin_claimed(fet_pin_claimed));

`default_nettype wire

//--- tb/tb_gpio_pin_config_mux.sv
/*
  Self-checking bench: mode table, reset and unmapped access, deglitch, FET routing.
  Assumes the design, the host model and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_pin_config_mux;
  typedef struct packed {logic [2:0] pin; logic [15:0] wdata; logic oe; logic ibe;} gpcm_row_t;
  localparam gpcm_row_t ROWS [10] = '{
    {3'h0, 16'hff11, 1'b1, 1'b1}, {3'h1, 16'h0009, 1'b1, 1'b1}, {3'h2, 16'h0002, 1'b0, 1'b1},
    {3'h3, 16'h00c8, 1'b0, 1'b0}, {3'h4, 16'h0043, 1'b1, 1'b1}, {3'h5, 16'h00c4, 1'b0, 1'b1},
    {3'h0, 16'h0005, 1'b0, 1'b0}, {3'h1, 16'h0036, 1'b0, 1'b0}, {3'h2, 16'h0007, 1'b0, 1'b0},
    {3'h0, 16'h0043, 1'b1, 1'b1}};
  logic        clk, reset, reg_wr_en, reg_rd_en, reg_rvalid;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_q;
  logic [5:0]  pin_in, pin_out, pin_oe, ibe, pd, lvl, drv_en, drv_lvl;
  logic [3:0]  din, sel, sw, fet_drive, claimed;
  int          n_mismatch, compares;

  always #5 clk = ~clk;

  gpcm_top dut_u (.clk(clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_input_buffer_enable(ibe),
    .weak_pulldown_enable(pd), .pin_input_level(lvl), .din_debounced(din),
    .fet_drive_source_select(sel), .fet_software_data(sw), .fet_drive(fet_drive),
    .fet_pin_claimed(claimed));

  gpcm_host_model host_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .weak_pulldown_enable(pd),
    .host_drive_en(drv_en), .host_level(drv_lvl), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Trailing idle cycle keeps strobes from being raised again in the same step
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
    tick(1);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    int i;
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
      tick(1);
    if (i == 4)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    d = reg_rdata;
    tick(1);
  endtask

  initial
  begin
    int p;
    logic [15:0] w;
    logic exp_out;
    clk = 1'b0;
    reset = 1'b1;
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    {drv_en, drv_lvl, din, sel, sw} = '0;
    tick(16);
    reset = 1'b0;
    tick(1);
    foreach (ROWS[r])
    begin
      p = ROWS[r].pin;
      w = ROWS[r].wdata;
      din = 4'h5 ^ {4{r[0]}};
      wr_reg(8'h32 + {5'h0, ROWS[r].pin}, w);
      exp_out = w[2:0] == 3'h1 ? w[4] : w[2:0] == 3'h3 ? din[w[7:6]] : 1'b0;
      check({12'h0, pin_oe[p], ibe[p], pd[p], pin_out[p]},
            {12'h0, ROWS[r].oe, ROWS[r].ibe, w[3], exp_out});
      rd_reg(8'h32 + {5'h0, ROWS[r].pin}, rd_q);
      check(rd_q & (ROWS[r].ibe ? 16'hffdf : 16'hffff), w & 16'h00df);
    end
    reset = 1'b1;
    tick(4);
    reset = 1'b0;
    check({4'h0, pd, pin_oe}, 16'h0fc0);
    tick(1);
    wr_reg(8'h31, 16'hffff);
    wr_reg(8'h38, 16'hffff);
    for (int a = 8'h31; a <= 8'h38; a++)
    begin
      rd_reg(8'(a), rd_q);
      check(rd_q, (a == 8'h31 || a == 8'h38) ? 16'h0000 : 16'h0008);
    end
    drv_en = 6'h01;
    wr_reg(8'h32, 16'h0002);
    tick(12);
    drv_lvl = 6'h01;
    tick(3);
    drv_lvl = 6'h00;
    repeat (12)
    begin
      tick(1);
      check({15'h0, lvl[0]}, 16'h0000);
    end
    drv_lvl = 6'h01;
    tick(7);
    check({15'h0, lvl[0]}, 16'h0000);
    tick(3);
    check({15'h0, lvl[0]}, 16'h0001);
    rd_reg(8'h32, rd_q);
    check(rd_q, 16'h0022);
    wr_reg(8'h32, 16'h0000);
    check({14'h0, lvl[0], ibe[0]}, 16'h0000);
    sel = 4'h4;
    drv_en = 6'h12;
    drv_lvl = 6'h02;
    wr_reg(8'h33, 16'h0084);
    wr_reg(8'h36, 16'h0084);
    tick(4);
    check({8'h0, claimed, fet_drive}, 16'h0040);
    drv_lvl = 6'h10;
    sel = 4'h6;
    sw = 4'h9;
    tick(4);
    check({12'h0, fet_drive}, 16'h000d);
    tally_and_finish();
  end
endmodule

`default_nettype wire
